// ---- logic/dpi_pkg.sv ----
// Purpose: Shared constants for the DRAM pin interface
// Assumes: 25 MHz SDRAM clock
// Notes:   Command codes are {row, col, we} active-low levels
package dpi_pkg;
   localparam int          ADDR_W        = 14;
   localparam int          DATA_W        = 64;
   localparam int          CHK_W         = 8;
   localparam int          WE_COPIES     = 4;
   localparam int          STRAP_CLOCKS  = 4;
   localparam logic [2:0]  CMD_NOP       = 3'h7;
   localparam logic [2:0]  CMD_ACTIVE    = 3'h3;
   localparam logic [2:0]  CMD_READ      = 3'h5;
   localparam logic [2:0]  CMD_WRITE     = 3'h4;
   localparam logic [2:0]  CMD_PRECHARGE = 3'h2;
   localparam logic [2:0]  CMD_REFRESH   = 3'h1;
   localparam logic [1:0]  SOCKET_NEAR   = 2'h0;

   typedef enum logic [5:0] {
      DPI_STRAP   = 6'b000001,
      DPI_IDLE    = 6'b000010,
      DPI_ROW     = 6'b000100,
      DPI_COL     = 6'b001000,
      DPI_PRECHG  = 6'b010000,
      DPI_PWRDN   = 6'b100000
   } dpi_state_t;
endpackage

// ---- logic/dpi_sync.sv ----
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Single clock domain
// Notes:   First stage read only by second stage
`timescale 1ns/1ns
module dpi_sync #(
   parameter int W = 1
) (
   input  wire logic         CLK_I,
   input  wire logic         RESET_N_I,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] stage1;

   // Two flops, constant reset values
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         stage1 <= '0;
         q_o    <= '0;
      end else begin
         stage1 <= d_i;
         q_o    <= stage1;
      end
   end
endmodule

// ---- logic/dpi_top.sv ----
// Purpose: Pin side of the DRAM controller: address, strobes, data, clock enable
// Assumes: Core supplies one access at a time with a ready handshake
// Notes:   EDO burst steps the low address copy; SDRAM issues one word per access
//
// How it works
// - Row then column address share one multiplexed address bus.
// - Separate low address copy completes address; steps through values in EDO bursts.
// - Low copy changes for socket 0 accesses or when the lookahead shows socket 0 next, otherwise holds value.
// - Four write-enable outputs always carry the same value.
// - Commands encoded on row, column and write strobes; write enable strobes EDO.
// - 64-bit data bus driven for writes, sampled for reads.
// - Check-bit lines driven only while writing.
// - Clock enable high normally, low for power-down.
// - All banks precharged before clock enable drops.
// - Power-down entered only on power-management request.
// - Clock-enable pin is an input sampling the strap through reset window.
`timescale 1ns/1ns
module dpi_top
(
   input  wire logic                         CLK_I,
   input  wire logic                         RESET_N_I,
   input  wire logic                         PROCESSOR_RESET_N_I,
   input  wire logic                         REQ_VALID_I,
   output logic                              REQ_READY_O,
   input  wire logic                         REQ_WRITE_I,
   input  wire logic                         REQ_EDO_I,
   input  wire logic [1:0]                   REQ_SOCKET_I,
   input  wire logic [1:0]                   NEXT_SOCKET_I,
   input  wire logic                         NEXT_VALID_I,
   input  wire logic [dpi_pkg::ADDR_W-1:0]   REQ_ROW_I,
   input  wire logic [dpi_pkg::ADDR_W-1:0]   REQ_COL_I,
   input  wire logic [dpi_pkg::DATA_W-1:0]   REQ_WDATA_I,
   input  wire logic [dpi_pkg::CHK_W-1:0]    REQ_WCHK_I,
   input  wire logic                         PWRDN_REQ_I,
   output logic                              RD_VALID_O,
   output logic      [dpi_pkg::DATA_W-1:0]   RD_DATA_O,
   output logic      [dpi_pkg::CHK_W-1:0]    RD_CHK_O,
   output logic                              STRAP_O,
   output logic                              STRAP_DONE_O,
   output logic      [dpi_pkg::ADDR_W-1:0]   MUXED_ADDR_BUS_O,
   output logic      [1:0]                   LOW_ADDR_COPY_O,
   output logic                              ROW_STROBE_N_O,
   output logic                              COL_STROBE_N_O,
   output logic      [dpi_pkg::WE_COPIES-1:0] WRITE_EN_N_O,
   input  wire logic [dpi_pkg::DATA_W-1:0]   MEM_DATA_BUS_I,
   output logic      [dpi_pkg::DATA_W-1:0]   MEM_DATA_BUS_O,
   output logic                              MEM_DATA_BUS_OE_O,
   input  wire logic [dpi_pkg::CHK_W-1:0]    CHECK_BIT_BUS_I,
   output logic      [dpi_pkg::CHK_W-1:0]    CHECK_BIT_BUS_O,
   output logic                              CHECK_BIT_BUS_OE_O,
   input  wire logic                         CLK_EN_I,
   output logic                              CLK_EN_O,
   output logic                              CLK_EN_OE_O
);
   import dpi_pkg::*;

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic       processor_reset_n_n_s;
   logic       cke_s;
   logic [1:0] pin_q;

   // Processor reset and strap pin come from outside the clock domain
   dpi_sync #(.W(2)) u_sync (
      .CLK_I     (CLK_I),
      .RESET_N_I (RESET_N_I),
      .d_i       ({PROCESSOR_RESET_N_I, CLK_EN_I}),
      .q_o       (pin_q)
   );
   assign processor_reset_n_n_s = pin_q[1];
   assign cke_s      = pin_q[0];

   // ****************************************************************
   // Strap window
   // ****************************************************************
   logic [2:0] strap_cnt;
   logic       strap_done;
   logic       strap;

   // Window opens at system reset, closes 4 clocks after synchronised processor reset goes high (6 after the pin)
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         strap_cnt  <= '0;
         strap_done <= 1'b0;
      end else if (!processor_reset_n_n_s) begin
         strap_cnt  <= '0;
      end else if (!strap_done) begin
         if (strap_cnt == 3'(STRAP_CLOCKS - 1)) begin
            strap_done <= 1'b1;
         end
         strap_cnt <= strap_cnt + 3'h1;
      end
   end

   // Strap captured by a clocked process, never under reset
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         strap <= 1'b0;
      end else if (!strap_done) begin
         strap <= cke_s;
      end
   end

   assign STRAP_O      = strap;
   assign STRAP_DONE_O = strap_done;
   assign CLK_EN_OE_O  = strap_done;

   // ****************************************************************
   // Access sequencer
   // ****************************************************************
   dpi_state_t state;
   dpi_state_t next_state;
   logic       acc_write;
   logic       acc_edo;
   logic [1:0] acc_socket;
   logic [1:0] burst_cnt;
   logic       bank_open;

   // Power-down only on request, from idle directly with banks closed, or through precharge when a bank is open
   always_comb begin
      next_state = state;
      unique case (state)
         DPI_STRAP: begin
            if (strap_done) next_state = DPI_IDLE;
         end
         DPI_IDLE: begin
            if (PWRDN_REQ_I) begin
               next_state = bank_open ? DPI_PRECHG : DPI_PWRDN;
            end else if (REQ_VALID_I) begin
               next_state = DPI_ROW;
            end
         end
         DPI_ROW:    next_state = DPI_COL;
         DPI_COL: begin
            if (!acc_edo || burst_cnt == 2'h3) next_state = DPI_IDLE;
         end
         DPI_PRECHG: next_state = DPI_PWRDN;
         DPI_PWRDN: begin
            if (!PWRDN_REQ_I) next_state = DPI_IDLE;
         end
         default:    next_state = DPI_STRAP;
      endcase
   end

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) state <= DPI_STRAP;
      else            state <= next_state;
   end

   assign REQ_READY_O = (state == DPI_IDLE) && !PWRDN_REQ_I;

   // Capture access attributes on acceptance
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         acc_write  <= 1'b0;
         acc_edo    <= 1'b0;
         acc_socket <= SOCKET_NEAR;
      end else if (REQ_VALID_I && REQ_READY_O) begin
         acc_write  <= REQ_WRITE_I;
         acc_edo    <= REQ_EDO_I;
         acc_socket <= REQ_SOCKET_I;
      end
   end

   // Burst beat counter for EDO column phase
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I)              burst_cnt <= 2'h0;
      else if (state == DPI_COL)   burst_cnt <= burst_cnt + 2'h1;
      else                         burst_cnt <= 2'h0;
   end

   // Rows left open after SDRAM accesses, closed by precharge
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I)                              bank_open <= 1'b0;
      else if (state == DPI_ROW && !acc_edo)       bank_open <= 1'b1;
      else if (state == DPI_PRECHG)                bank_open <= 1'b0;
   end

   // ****************************************************************
   // Pin drivers
   // ****************************************************************
   logic [ADDR_W-1:0] row_addr;
   logic [ADDR_W-1:0] col_addr;
   logic [2:0]        cmd;
   logic              we_n;
   logic              near_hit;

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         row_addr <= '0;
         col_addr <= '0;
      end else if (REQ_VALID_I && REQ_READY_O) begin
         row_addr <= REQ_ROW_I;
         col_addr <= REQ_COL_I;
      end
   end

   // Row phase then column phase on one bus
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         MUXED_ADDR_BUS_O <= '0;
      end else if (next_state == DPI_ROW) begin
         MUXED_ADDR_BUS_O <= REQ_ROW_I;
      end else if (next_state == DPI_COL && state == DPI_ROW) begin
         MUXED_ADDR_BUS_O <= col_addr;
      end
   end

   // Near socket hit for access in flight, access being taken, or lookahead
   // Without the taken term the row phase of a socket 0 access would be missed
   assign near_hit = ((state != DPI_IDLE) && (acc_socket == SOCKET_NEAR)) ||
                     (REQ_VALID_I && REQ_READY_O && REQ_SOCKET_I == SOCKET_NEAR) ||
                     (NEXT_VALID_I && NEXT_SOCKET_I == SOCKET_NEAR);

   // Low copy tracks socket 0 and any access with a socket 0 lookahead; other accesses see it frozen for less load
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         LOW_ADDR_COPY_O <= 2'h0;
      end else if (near_hit) begin
         if (next_state == DPI_ROW) begin
            LOW_ADDR_COPY_O <= REQ_ROW_I[1:0];
         end else if (next_state == DPI_COL && state == DPI_ROW) begin
            LOW_ADDR_COPY_O <= col_addr[1:0];
         end else if (state == DPI_COL && acc_edo && next_state == DPI_COL) begin
            LOW_ADDR_COPY_O <= LOW_ADDR_COPY_O + 2'h1;
         end
      end
   end

   // Command encoding; strap phase forces no operation
   always_comb begin
      unique case (next_state)
         DPI_ROW:    cmd = CMD_ACTIVE;
         DPI_COL:    cmd = acc_write ? CMD_WRITE : CMD_READ;
         DPI_PRECHG: cmd = CMD_PRECHARGE;
         default:    cmd = CMD_NOP;
      endcase
   end

   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         ROW_STROBE_N_O <= 1'b1;
         COL_STROBE_N_O <= 1'b1;
         we_n           <= 1'b1;
      end else begin
         ROW_STROBE_N_O <= cmd[2];
         COL_STROBE_N_O <= cmd[1];
         we_n           <= cmd[0];
      end
   end

   // One logical strobe fanned out only for electrical load
   assign WRITE_EN_N_O = {WE_COPIES{we_n}};

   // Write data and direction
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         MEM_DATA_BUS_O     <= '0;
         CHECK_BIT_BUS_O    <= '0;
         MEM_DATA_BUS_OE_O  <= 1'b0;
         CHECK_BIT_BUS_OE_O <= 1'b0;
      end else begin
         if (REQ_VALID_I && REQ_READY_O) begin
            MEM_DATA_BUS_O  <= REQ_WDATA_I;
            CHECK_BIT_BUS_O <= REQ_WCHK_I;
         end
         MEM_DATA_BUS_OE_O  <= (next_state == DPI_COL) && acc_write;
         CHECK_BIT_BUS_OE_O <= (next_state == DPI_COL) && acc_write;
      end
   end

   // Read capture one cycle after the column command
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         RD_VALID_O <= 1'b0;
         RD_DATA_O  <= '0;
         RD_CHK_O   <= '0;
      end else begin
         RD_VALID_O <= (state == DPI_COL) && !acc_write;
         if ((state == DPI_COL) && !acc_write) begin
            RD_DATA_O <= MEM_DATA_BUS_I;
            RD_CHK_O  <= CHECK_BIT_BUS_I;
         end
      end
   end

   // Clock enable low only in power-down
   always_ff @(posedge CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) CLK_EN_O <= 1'b1;
      else            CLK_EN_O <= (next_state != DPI_PWRDN);
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_we_copies_equal: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      WRITE_EN_N_O == {WE_COPIES{WRITE_EN_N_O[0]}}) else $error("write enables differ");

   chk_chk_dir_write: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      CHECK_BIT_BUS_OE_O |-> (!WRITE_EN_N_O[0] && !COL_STROBE_N_O)) else $error("check drive");

   chk_data_dir_match: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      MEM_DATA_BUS_OE_O == CHECK_BIT_BUS_OE_O) else $error("data direction mismatch");

   chk_cke_fall_closed: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      $fell(CLK_EN_O) |-> !bank_open) else $error("power-down with open bank");

   chk_cke_only_req: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      $fell(CLK_EN_O) |-> $past(PWRDN_REQ_I)) else $error("power-down without request");

   chk_strap_no_cmd: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      !strap_done |-> (ROW_STROBE_N_O && COL_STROBE_N_O && CLK_EN_O && !CLK_EN_OE_O))
      else $error("command during strap");

   sequence s_proc_rise;
      $rose(processor_reset_n_n_s) && !strap_done;
   endsequence
   chk_strap_window: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      s_proc_rise |-> !strap_done [*4] ##1 strap_done) else $error("strap window length");

   chk_low_hold_far: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      !near_hit |=> $stable(LOW_ADDR_COPY_O)) else $error("low copy moved for far socket");

   // Activate only; precharge also drops the row strobe but has no column phase
   sequence s_activate;
      !ROW_STROBE_N_O && COL_STROBE_N_O && WRITE_EN_N_O[0];
   endsequence
   sequence s_column;
      ROW_STROBE_N_O && !COL_STROBE_N_O && (MUXED_ADDR_BUS_O == col_addr);
   endsequence
   chk_row_then_col: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
      s_activate |=> s_column)
      else $error("column phase missing");
endmodule

// ---- dv/dpi_dram_model.sv ----
// Purpose: Behavioural DIMM array on the far side of the pin interface
// Assumes: Strobes sampled on the rising clock edge
// Notes:   Released data lines fall to the pull-down level
`timescale 1ns/1ns
module dpi_dram_model #(
   parameter logic STRAP_VAL = 1'h1
) (
   input  wire logic        clk_i,
   input  wire logic        row_n_i,
   input  wire logic        col_n_i,
   input  wire logic        we_n_i,
   input  wire logic [13:0] addr_i,
   input  wire logic [63:0] dq_i,
   input  wire logic        dq_oe_i,
   input  wire logic [7:0]  cb_i,
   input  wire logic        cb_oe_i,
   input  wire logic        cke_i,
   input  wire logic        cke_oe_i,
   output logic      [63:0] dq_o,
   output logic      [7:0]  cb_o,
   output logic             cke_o
);
   logic [71:0] mem [logic [27:0]];
   logic [13:0] row;
   // Row latched on activate, word stored on write command
   always @(posedge clk_i) begin
      if (!row_n_i && col_n_i && we_n_i) row <= addr_i;
      if (row_n_i && !col_n_i && !we_n_i) mem[{row, addr_i}] = {cb_i, dq_i};
   end
   // Pin levels: pull-downs unless someone drives; strap holds the enable pin
   always @* begin
      {cb_o, dq_o} = 72'h0;
      if (dq_oe_i) dq_o = dq_i;
      if (cb_oe_i) cb_o = cb_i;
      if (row_n_i && !col_n_i && we_n_i && mem.exists({row, addr_i}))
         {cb_o, dq_o} = mem[{row, addr_i}];
      cke_o = cke_oe_i ? cke_i : STRAP_VAL;
   end
endmodule

// ---- dv/dpi_top_tb.sv ----
// Purpose: Self-checking bench for the DRAM pin interface
// Assumes: Strap pin pulled high by the array model
// Notes:   Each access is recorded for eight cycles, then judged
`timescale 1ns/1ns
module dpi_top_tb;
   import dpi_pkg::*;
   logic CLK_I, RESET_N_I, PROCESSOR_RESET_N_I, REQ_VALID_I, REQ_READY_O, REQ_WRITE_I;
   logic REQ_EDO_I, NEXT_VALID_I, PWRDN_REQ_I, RD_VALID_O, STRAP_O, STRAP_DONE_O;
   logic ROW_STROBE_N_O, COL_STROBE_N_O, MEM_DATA_BUS_OE_O, CHECK_BIT_BUS_OE_O;
   logic CLK_EN_I, CLK_EN_O, CLK_EN_OE_O;
   logic [1:0]  REQ_SOCKET_I, NEXT_SOCKET_I, LOW_ADDR_COPY_O;
   logic [3:0]  WRITE_EN_N_O;
   logic [13:0] REQ_ROW_I, REQ_COL_I, MUXED_ADDR_BUS_O;
   logic [63:0] REQ_WDATA_I, RD_DATA_O, MEM_DATA_BUS_I, MEM_DATA_BUS_O;
   logic [7:0]  REQ_WCHK_I, RD_CHK_O, CHECK_BIT_BUS_I, CHECK_BIT_BUS_O;
   logic [2:0]  s_cmd [8];
   logic [13:0] s_ad  [8];
   logic [1:0]  s_lo  [8];
   logic [71:0] s_dat [8];
   logic        s_rv  [8];
   int          error_cnt = 0;
   int          tests_run = 0;

   dpi_top DUT (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
      .PROCESSOR_RESET_N_I(PROCESSOR_RESET_N_I), .REQ_VALID_I(REQ_VALID_I),
      .REQ_READY_O(REQ_READY_O), .REQ_WRITE_I(REQ_WRITE_I), .REQ_EDO_I(REQ_EDO_I),
      .REQ_SOCKET_I(REQ_SOCKET_I), .NEXT_SOCKET_I(NEXT_SOCKET_I),
      .NEXT_VALID_I(NEXT_VALID_I), .REQ_ROW_I(REQ_ROW_I), .REQ_COL_I(REQ_COL_I),
      .REQ_WDATA_I(REQ_WDATA_I), .REQ_WCHK_I(REQ_WCHK_I), .PWRDN_REQ_I(PWRDN_REQ_I),
      .RD_VALID_O(RD_VALID_O), .RD_DATA_O(RD_DATA_O), .RD_CHK_O(RD_CHK_O),
      .STRAP_O(STRAP_O), .STRAP_DONE_O(STRAP_DONE_O), .MUXED_ADDR_BUS_O(MUXED_ADDR_BUS_O),
      .LOW_ADDR_COPY_O(LOW_ADDR_COPY_O), .ROW_STROBE_N_O(ROW_STROBE_N_O),
      .COL_STROBE_N_O(COL_STROBE_N_O), .WRITE_EN_N_O(WRITE_EN_N_O),
      .MEM_DATA_BUS_I(MEM_DATA_BUS_I), .MEM_DATA_BUS_O(MEM_DATA_BUS_O),
      .MEM_DATA_BUS_OE_O(MEM_DATA_BUS_OE_O), .CHECK_BIT_BUS_I(CHECK_BIT_BUS_I),
      .CHECK_BIT_BUS_O(CHECK_BIT_BUS_O), .CHECK_BIT_BUS_OE_O(CHECK_BIT_BUS_OE_O),
      .CLK_EN_I(CLK_EN_I), .CLK_EN_O(CLK_EN_O), .CLK_EN_OE_O(CLK_EN_OE_O));

   dpi_dram_model u_dimm (.clk_i(CLK_I), .row_n_i(ROW_STROBE_N_O),
      .col_n_i(COL_STROBE_N_O), .we_n_i(WRITE_EN_N_O[0]), .addr_i(MUXED_ADDR_BUS_O),
      .dq_i(MEM_DATA_BUS_O), .dq_oe_i(MEM_DATA_BUS_OE_O), .cb_i(CHECK_BIT_BUS_O),
      .cb_oe_i(CHECK_BIT_BUS_OE_O), .cke_i(CLK_EN_O), .cke_oe_i(CLK_EN_OE_O),
      .dq_o(MEM_DATA_BUS_I), .cb_o(CHECK_BIT_BUS_I), .cke_o(CLK_EN_I));

   // 25 MHz clock
   initial begin
      CLK_I = 1'b0;
      forever #20 CLK_I = ~CLK_I;
   end

   task automatic check(input bit ok, input string msg);
      tests_run++;
      if (!ok) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask

   task report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Enable pin must stay an input until the strap window closes
   task automatic t_strap();
      int n;
      n = 0;
      check(CLK_EN_OE_O === 1'b0 && REQ_READY_O === 1'b0, "pin driven in reset");
      PROCESSOR_RESET_N_I = 1'b1;
      while (STRAP_DONE_O !== 1'b1 && n < 20) begin
         check(ROW_STROBE_N_O === 1'b1 && COL_STROBE_N_O === 1'b1, "command in strap");
         check(CLK_EN_OE_O === 1'b0, "pin driven in window");
         @(posedge CLK_I); #1; n++;
      end
      check(n == STRAP_CLOCKS + 2, "strap window length");
      check(STRAP_O === 1'b1 && CLK_EN_O === 1'b1, "strap value");
      $display("test strap done");
   endtask

   // One access, recorded for eight cycles after it is taken
   task automatic access(input logic wr, edo, input logic [1:0] sk,
                         input logic [13:0] row, col, input logic [71:0] d,
                         input logic nx = 1'b0);
      int i; int r; int n; int got; logic [1:0] lo0; logic near;
      r = -1; n = 0; got = 0; lo0 = LOW_ADDR_COPY_O; near = (sk == SOCKET_NEAR) || nx;
      NEXT_VALID_I = nx; NEXT_SOCKET_I = nx ? SOCKET_NEAR : 2'h1;
      REQ_WRITE_I = wr; REQ_EDO_I = edo; REQ_SOCKET_I = sk;
      REQ_ROW_I = row; REQ_COL_I = col; {REQ_WCHK_I, REQ_WDATA_I} = d;
      REQ_VALID_I = 1'b1;
      while (REQ_READY_O !== 1'b1 && n < 20) begin
         @(posedge CLK_I); #1; n++;
      end
      check(n < 20, "request never taken");
      for (i = 0; i < 8; i++) begin
         @(posedge CLK_I); #1;
         REQ_VALID_I = 1'b0;
         s_cmd[i] = {ROW_STROBE_N_O, COL_STROBE_N_O, WRITE_EN_N_O[0]};
         s_ad[i] = MUXED_ADDR_BUS_O;
         s_lo[i] = LOW_ADDR_COPY_O;
         s_rv[i] = RD_VALID_O;
         s_dat[i] = RD_VALID_O ? {RD_CHK_O, RD_DATA_O} : {CHECK_BIT_BUS_O, MEM_DATA_BUS_O};
         check(WRITE_EN_N_O === {4{WRITE_EN_N_O[0]}}, "write enables differ");
         check(CHECK_BIT_BUS_OE_O === (wr && s_cmd[i] === CMD_WRITE), "check drive");
         check(MEM_DATA_BUS_OE_O === CHECK_BIT_BUS_OE_O, "data drive");
         check(CLK_EN_O === 1'b1, "power-down unasked");
         if (s_cmd[i] === CMD_ACTIVE && r < 0) r = i;
         if (s_rv[i] === 1'b1) got++;
         if (s_rv[i] === 1'b1) check(s_dat[i] === d, "read data");
      end
      check(r >= 0 && r < 3, "no row phase");
      if (r < 0 || r > 2) r = 0;
      check(s_ad[r] === row && s_ad[r+1] === col, "address phases");
      check(s_cmd[r+1] === (wr ? CMD_WRITE : CMD_READ), "column command");
      check(s_lo[r] === (near ? row[1:0] : lo0), "low copy row");
      for (i = 0; i < (edo ? 4 : 1); i++)
         check(s_lo[r+1+i] === (near ? col[1:0] + i[1:0] : lo0), "low copy");
      if (wr) check(s_dat[r+1] === d, "write data");
      check(got == (wr ? 0 : (edo ? 4 : 1)), "read strobe count");
      NEXT_VALID_I = 1'b0;
      $display("test access done wr=%0d edo=%0d socket=%0d", wr, edo, sk);
   endtask

   // Precharge must come before the enable drops, and waking must follow
   task automatic t_pwrdn();
      int i; int pre; int low;
      pre = -1; low = -1;
      PWRDN_REQ_I = 1'b1;
      for (i = 0; i < 8; i++) begin
         @(posedge CLK_I); #1;
         if ({ROW_STROBE_N_O, COL_STROBE_N_O, WRITE_EN_N_O[0]} === CMD_PRECHARGE && pre < 0)
            pre = i;
         if (CLK_EN_O === 1'b0 && low < 0) low = i;
      end
      check(pre >= 0 && low > pre, "no precharge first");
      check(CLK_EN_O === 1'b0 && REQ_READY_O === 1'b0, "not powered down");
      PWRDN_REQ_I = 1'b0;
      @(posedge CLK_I); #1;
      @(posedge CLK_I); #1;
      check(CLK_EN_O === 1'b1, "no wake");
      $display("test power-down done");
   endtask

   // Watchdog, well beyond the expected run length
   initial begin
      #(40 * 3000);
      error_cnt++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      RESET_N_I = 1'b0; PROCESSOR_RESET_N_I = 1'b0; REQ_VALID_I = 1'b0;
      REQ_WRITE_I = 1'b0; REQ_EDO_I = 1'b0; REQ_SOCKET_I = 2'h0; NEXT_SOCKET_I = 2'h1;
      NEXT_VALID_I = 1'b0; REQ_ROW_I = 14'h0; REQ_COL_I = 14'h0; REQ_WDATA_I = 64'h0;
      REQ_WCHK_I = 8'h0; PWRDN_REQ_I = 1'b0;
      repeat (8) @(posedge CLK_I);
      #1 RESET_N_I = 1'b1;
      t_strap();
      access(1'b1, 1'b0, 2'h0, 14'h1235, 14'h0ABE, 72'hA5_0123456789ABCDEF);
      access(1'b0, 1'b0, 2'h0, 14'h1235, 14'h0ABE, 72'hA5_0123456789ABCDEF);
      access(1'b1, 1'b1, 2'h0, 14'h0042, 14'h0100, 72'h3C_FEDCBA9876543210);
      access(1'b0, 1'b1, 2'h0, 14'h0042, 14'h0100, 72'h3C_FEDCBA9876543210);
      access(1'b1, 1'b0, 2'h1, 14'h3FFF, 14'h2223, 72'hFF_FFFF0000FFFF0000);
      access(1'b0, 1'b0, 2'h2, 14'h3FFF, 14'h2223, 72'hFF_FFFF0000FFFF0000);
      access(1'b1, 1'b0, 2'h2, 14'h1236, 14'h0ABD, 72'h5A_0F0F0F0F0F0F0F0F, 1'b1);
      t_pwrdn();
      report_and_stop();
   end
endmodule
